// *** hdl/bridge_cfg_pkg.sv ***
// Constants, types and register map of the bridge clock and receiver configuration block
// Behaviour
// - HS clock divided by divide code plus one
// - Reference clock multiplied by multiply code plus one
// - PLL enable bit starts/stops PLL, resets 0
// - Lane code selects four to one lanes
// - Tolerance-off bit rejects single leader bit errors
// - Data lane equalization none, 1 dB, 2 dB
// - Clock lane equalization uses same encoding
// - Clock band code in 5 MHz steps
// - Source select: 0 reference, 1 HS clock
package bridge_cfg_pkg;

   // ==========================================================
   // Register offsets (local serial subaddresses)
   // ==========================================================
   localparam logic [7:0] SOFT_RESET_OFS       = 8'h09;
   localparam logic [7:0] CLOCK_SOURCE_OFS     = 8'h0A;
   localparam logic [7:0] CLK_DIV_MULT_OFS     = 8'h0B;
   localparam logic [7:0] PLL_CONTROL_OFS      = 8'h0D;
   localparam logic [7:0] LANE_SETUP_OFS       = 8'h10;
   localparam logic [7:0] EQUALIZATION_OFS     = 8'h11;
   localparam logic [7:0] CLOCK_BAND_OFS       = 8'h12;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int SOFT_RESET_BIT   = 0;
   localparam int PLL_STATUS_BIT   = 7;
   localparam int RANGE_LSB        = 1;
   localparam int SOURCE_BIT       = 0;
   localparam int DIVIDE_LSB       = 3;
   localparam int MULTIPLY_LSB     = 0;
   localparam int PLL_ENABLE_BIT   = 0;
   localparam int LANE_LSB         = 3;
   localparam int TOL_OFF_BIT      = 0;
   localparam int DATA_EQ_LSB      = 6;
   localparam int CLK_EQ_LSB       = 2;

   // ==========================================================
   // Reset values and code limits
   // ==========================================================
   localparam logic [2:0] RANGE_RESET      = 3'h5;
   localparam logic [1:0] LANE_RESET       = 2'h3;
   localparam logic [4:0] DIVIDE_CODE_MAX  = 5'h18;
   localparam logic [7:0] BAND_CODE_MIN    = 8'h08;
   localparam logic [7:0] BAND_CODE_MAX    = 8'h64;
   localparam logic [6:0] DEVICE_ADDR_DEF  = 7'h2C;  // Arbitrary value

   // ==========================================================
   // Serial slave states
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_SUB   = 3'b010,
      ST_WDATA = 3'b011,
      ST_ACK   = 3'b100,
      ST_RLOAD = 3'b101,
      ST_RDATA = 3'b110,
      ST_RACK  = 3'b111
   } serial_state_t;

   // ==========================================================
   // Configuration carriers
   // ==========================================================
   typedef struct packed {
      logic       pixel_clock_source_select;  // 0 reference, 1 HS clock
      logic [2:0] outputClockRange;           // Output clock band
      logic [4:0] hsDivideCode;               // Divide by code plus one
      logic [1:0] ref_clock_multiply_code;    // Multiply by code plus one
      logic       pllEnable;                  // PLL run request
   } pll_cfg_t;

   typedef struct packed {
      logic [1:0] input_lane_count;           // Lane code as stored
      logic       leader_error_tolerance_off; // 1 rejects any leader error
      logic [1:0] data_lane_equalization;
      logic [1:0] clock_lane_equalization;
      logic [7:0] input_clock_band_code;
   } rx_cfg_t;

   typedef struct packed {
      logic [4:0] divideEffective;            // Code used by divider
      logic [1:0] multiplyEffective;          // Code used by multiplier
      logic [2:0] activeLanes;                // 1 to 4
      logic       bandValid;                  // Band code not reserved
   } derived_cfg_t;

endpackage

// *** hdl/pixel_clock_divider.sv ***
// Programmable tick divider producing the pixel clock tick from the source tick
module pixel_clock_divider #(
   parameter int DIV_WIDTH = 5
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   input  wire logic                 clear,
   input  wire logic                 srcTick,
   input  wire logic [DIV_WIDTH-1:0] divCode,
   output      logic                 outTick
);
   import bridge_cfg_pkg::*;

   // ==========================================================
   // Parameter check
   // ==========================================================
   // Narrower counters cannot reach the largest divide code
   if (DIV_WIDTH < 5) begin : g_width_check
      $error("pixel_clock_divider: DIV_WIDTH must be at least 5");
   end

   logic [DIV_WIDTH-1:0] count_reg;  // Source ticks seen in this period

   // ==========================================================
   // Divide counter
   // ==========================================================
   // Clear holds the phase at zero so a restart is aligned
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
         outTick   <= 1'b0;
      end else if (clear) begin
         count_reg <= '0;
         outTick   <= 1'b0;
      end else begin
         outTick <= 1'b0;
         if (srcTick) begin
            if (count_reg >= divCode) begin
               count_reg <= '0;
               outTick   <= 1'b1;
            end else begin
               count_reg <= count_reg + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule

// *** hdl/bridge_clock_config.sv ***
// Serial-slave register bank for pixel clock, PLL and receiver setup
module bridge_clock_config #(
   parameter logic [6:0] DEVICE_ADDR = bridge_cfg_pkg::DEVICE_ADDR_DEF  // Arbitrary value
) (
   input  wire logic                         ref_clk,
   input  wire logic                         rstn,
   input  wire logic                         scl,
   input  wire logic                         sdaIn,
   output      logic                         sdaOut,
   output      logic                         sdaOeN,
   input  wire logic                         hsClkTick,
   input  wire logic                         refClkTick,
   output      bridge_cfg_pkg::pll_cfg_t     pllCfg,
   output      bridge_cfg_pkg::rx_cfg_t      rxCfg,
   output      bridge_cfg_pkg::derived_cfg_t derivedCfg,
   output      logic                         pllRunning,
   output      logic                         softResetPulse,
   output      logic                         pixelTick
);
   import bridge_cfg_pkg::*;

   // ==========================================================
   // Declarations
   // ==========================================================
   serial_state_t state_reg;      // Serial slave state
   serial_state_t afterAck_reg;   // State entered after the ack bit
   logic [2:0]    bitCnt_reg;     // Bit index inside a byte
   logic [7:0]    shift_reg;      // Shift register for both directions
   logic          byteFull_reg;   // Eight bits received, ack pending
   logic [7:0]    subAddr_reg;    // Register pointer, auto-increments
   logic          wrStb_reg;      // One-cycle register write strobe
   logic [7:0]    wrAddr_reg;     // Write target
   logic [7:0]    wrData_reg;     // Write value
   logic          sclPrev_reg;    // Last clock line sample
   logic          sdaPrev_reg;    // Last data line sample
   logic [7:0]    rdByte;         // Read value at the pointer
   logic          sclRise;
   logic          sclFall;
   logic          startCond;
   logic          stopCond;
   logic          srcTick;        // Tick of the selected source

   // ==========================================================
   // Line edge and framing detection
   // ==========================================================
   // Inputs are already synchronous, one sample of history is enough
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
      end else begin
         sclPrev_reg <= scl;
         sdaPrev_reg <= sdaIn;
      end
   end

   assign sclRise   = scl & ~sclPrev_reg;
   assign sclFall   = ~scl & sclPrev_reg;
   assign startCond = scl & sclPrev_reg & sdaPrev_reg & ~sdaIn;
   assign stopCond  = scl & sclPrev_reg & ~sdaPrev_reg & sdaIn;

   // ==========================================================
   // Read multiplexer
   // ==========================================================
   // reserved read zero
   always_comb begin
      case (subAddr_reg)
         CLOCK_SOURCE_OFS: rdByte = {pllRunning, 3'b000, pllCfg.outputClockRange,
                                     pllCfg.pixel_clock_source_select};
         CLK_DIV_MULT_OFS: rdByte = {pllCfg.hsDivideCode, 1'b0,
                                     pllCfg.ref_clock_multiply_code};
         PLL_CONTROL_OFS:  rdByte = {7'b000_0000, pllCfg.pllEnable};
         LANE_SETUP_OFS:   rdByte = {3'b000, rxCfg.input_lane_count, 2'b00,
                                     rxCfg.leader_error_tolerance_off};
         EQUALIZATION_OFS: rdByte = {rxCfg.data_lane_equalization, 2'b00,
                                     rxCfg.clock_lane_equalization, 2'b00};
         CLOCK_BAND_OFS:   rdByte = rxCfg.input_clock_band_code;
         // Soft reset reads zero, unmapped addresses read zero
         default:          rdByte = 8'h00;
      endcase
   end

   // ==========================================================
   // Serial slave
   // ==========================================================
   // Open-drain: only ever pulls low, so the data output stays 0
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sdaOut <= 1'b0;
      end else begin
         sdaOut <= 1'b0;
      end
   end

   // Byte framing, ack generation, pointer handling and read shifting
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg    <= ST_IDLE;
         afterAck_reg <= ST_IDLE;
         bitCnt_reg   <= 3'h0;
         shift_reg    <= 8'h00;
         byteFull_reg <= 1'b0;
         subAddr_reg  <= 8'h00;
         sdaOeN       <= 1'b1;
         wrStb_reg    <= 1'b0;
         wrAddr_reg   <= 8'h00;
         wrData_reg   <= 8'h00;
      end else begin
         wrStb_reg <= 1'b0;
         if (stopCond) begin
            // Stop always frees the line
            state_reg    <= ST_IDLE;
            byteFull_reg <= 1'b0;
            sdaOeN       <= 1'b1;
         end else if (startCond) begin
            // Start or repeated start restarts address phase
            state_reg    <= ST_ADDR;
            bitCnt_reg   <= 3'h0;
            byteFull_reg <= 1'b0;
            sdaOeN       <= 1'b1;
         end else if (sclRise) begin
            case (state_reg)
               ST_ADDR, ST_SUB, ST_WDATA: begin
                  shift_reg  <= {shift_reg[6:0], sdaIn};
                  bitCnt_reg <= bitCnt_reg + 3'h1;
                  if (bitCnt_reg == 3'h7) begin
                     byteFull_reg <= 1'b1;
                  end
               end
               ST_RDATA: begin
                  bitCnt_reg <= bitCnt_reg + 3'h1;
                  if (bitCnt_reg == 3'h7) begin
                     state_reg <= ST_RACK;
                  end
               end
               ST_RACK: begin
                  // Master nack ends the read burst
                  state_reg <= sdaIn ? ST_IDLE : ST_RLOAD;
               end
               default: begin
               end
            endcase
         end else if (sclFall) begin
            case (state_reg)
               ST_ADDR: begin
                  if (byteFull_reg) begin
                     byteFull_reg <= 1'b0;
                     if (shift_reg[7:1] == DEVICE_ADDR) begin
                        sdaOeN       <= 1'b0;
                        state_reg    <= ST_ACK;
                        afterAck_reg <= shift_reg[0] ? ST_RLOAD : ST_SUB;
                     end else begin
                        // Other slave addressed: stay silent till next start
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               ST_SUB: begin
                  if (byteFull_reg) begin
                     byteFull_reg <= 1'b0;
                     subAddr_reg  <= shift_reg;
                     sdaOeN       <= 1'b0;
                     state_reg    <= ST_ACK;
                     afterAck_reg <= ST_WDATA;
                  end
               end
               ST_WDATA: begin
                  if (byteFull_reg) begin
                     byteFull_reg <= 1'b0;
                     wrStb_reg    <= 1'b1;
                     wrAddr_reg   <= subAddr_reg;
                     wrData_reg   <= shift_reg;
                     subAddr_reg  <= subAddr_reg + 8'h01;
                     sdaOeN       <= 1'b0;
                     state_reg    <= ST_ACK;
                     afterAck_reg <= ST_WDATA;
                  end
               end
               ST_ACK, ST_RLOAD: begin
                  bitCnt_reg <= 3'h0;
                  if (state_reg == ST_RLOAD || afterAck_reg == ST_RLOAD) begin
                     // Load and present the first bit of the read byte
                     shift_reg   <= rdByte;
                     sdaOeN      <= rdByte[7];
                     subAddr_reg <= subAddr_reg + 8'h01;
                     state_reg   <= ST_RDATA;
                  end else begin
                     sdaOeN    <= 1'b1;
                     state_reg <= afterAck_reg;
                  end
               end
               ST_RDATA: begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  sdaOeN    <= shift_reg[6];
               end
               ST_RACK: begin
                  sdaOeN <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Configuration registers
   // ==========================================================
   // Soft reset never touches these, so settings survive it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pllCfg <= '{pixel_clock_source_select: 1'b0, outputClockRange: RANGE_RESET,
                     hsDivideCode: 5'h00, ref_clock_multiply_code: 2'h0, pllEnable: 1'b0};
         rxCfg  <= '{input_lane_count: LANE_RESET, leader_error_tolerance_off: 1'b0,
                     data_lane_equalization: 2'h0, clock_lane_equalization: 2'h0,
                     input_clock_band_code: 8'h00};
      end else if (wrStb_reg) begin
         case (wrAddr_reg)
            CLOCK_SOURCE_OFS: begin
               pllCfg.pixel_clock_source_select <= wrData_reg[SOURCE_BIT];
               pllCfg.outputClockRange <= wrData_reg[RANGE_LSB +: 3];
            end
            CLK_DIV_MULT_OFS: begin
               pllCfg.hsDivideCode            <= wrData_reg[DIVIDE_LSB +: 5];
               pllCfg.ref_clock_multiply_code <= wrData_reg[MULTIPLY_LSB +: 2];
            end
            PLL_CONTROL_OFS: pllCfg.pllEnable <= wrData_reg[PLL_ENABLE_BIT];
            LANE_SETUP_OFS: begin
               rxCfg.input_lane_count <= wrData_reg[LANE_LSB +: 2];
               rxCfg.leader_error_tolerance_off <= wrData_reg[TOL_OFF_BIT];
            end
            EQUALIZATION_OFS: begin
               rxCfg.data_lane_equalization  <= wrData_reg[DATA_EQ_LSB +: 2];
               rxCfg.clock_lane_equalization <= wrData_reg[CLK_EQ_LSB +: 2];
            end
            CLOCK_BAND_OFS: rxCfg.input_clock_band_code <= wrData_reg;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Soft reset strobe
   // ==========================================================
   // Self-clearing: the bit itself is never stored
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         softResetPulse <= 1'b0;
      end else begin
         softResetPulse <= wrStb_reg && (wrAddr_reg == SOFT_RESET_OFS) &&
                           wrData_reg[SOFT_RESET_BIT];
      end
   end

   // ==========================================================
   // PLL status and decoded settings
   // ==========================================================
   // Status follows the enable one cycle later; lock is not modelled
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pllRunning <= 1'b0;
      end else begin
         pllRunning <= pllCfg.pllEnable;
      end
   end

   // Decoded values the clock and receiver paths actually use
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         derivedCfg <= '{divideEffective: 5'h00, multiplyEffective: 2'h0,
                         activeLanes: 3'h1, bandValid: 1'b0};
      end else begin
         if (!pllCfg.pixel_clock_source_select) begin
            derivedCfg.divideEffective <= 5'h00;
         end else if (pllCfg.hsDivideCode > DIVIDE_CODE_MAX) begin
            // Reserved codes clamp to the slowest legal ratio
            derivedCfg.divideEffective <= DIVIDE_CODE_MAX;
         end else begin
            derivedCfg.divideEffective <= pllCfg.hsDivideCode;
         end
         derivedCfg.multiplyEffective <= pllCfg.pixel_clock_source_select ? 2'h0 :
                                         pllCfg.ref_clock_multiply_code;
         derivedCfg.activeLanes <= 3'h4 - {1'b0, rxCfg.input_lane_count};
         derivedCfg.bandValid <= (rxCfg.input_clock_band_code >= BAND_CODE_MIN) &&
                                 (rxCfg.input_clock_band_code <= BAND_CODE_MAX);
      end
   end

   // ==========================================================
   // Pixel clock tick generation
   // ==========================================================
   // pick source tick
   assign srcTick = pllCfg.pixel_clock_source_select ? hsClkTick : refClkTick;

   // Divider halts while the PLL is off or during soft reset
   pixel_clock_divider #(
      .DIV_WIDTH (5)
   ) u_divider (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .clear   (softResetPulse | ~pllRunning),
      .srcTick (srcTick),
      .divCode (derivedCfg.divideEffective),
      .outTick (pixelTick)
   );

endmodule

// *** sim/cfg_host_model.sv ***
// Serial configuration master and source clock tick model
module cfg_host_model (
   input  wire logic ref_clk,
   input  wire logic sdaOeN,
   output      logic scl,
   output      logic sdaIn,
   output      logic hsClkTick,
   output      logic refClkTick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sdaDrv = 1'b1;  // Master side of the wire
   logic [1:0] hsCnt  = 2'h0;  // HS tick every third cycle
   initial begin
      scl = 1'b1;
      hsClkTick = 1'b0;
      refClkTick = 1'b0;
   end
   // Pull-up, so either party may hold the line low
   assign sdaIn = sdaDrv & sdaOeN;
   always @(posedge ref_clk) begin
      hsCnt <= (hsCnt == 2'h2) ? 2'h0 : hsCnt + 2'h1;
      hsClkTick <= (hsCnt == 2'h2);
      refClkTick <= !refClkTick;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Start or repeated start; extra wait lets an ack release first
   task automatic start();
      sdaDrv <= 1'b1;
      wt(2);
      scl <= 1'b1;
      wt(3);
      sdaDrv <= 1'b0;
      wt(3);
      scl <= 1'b0;
      wt(2);
   endtask
   task automatic stop();
      sdaDrv <= 1'b0;
      wt(2);
      scl <= 1'b1;
      wt(3);
      sdaDrv <= 1'b1;
      wt(3);
   endtask
   // One bit, data set while low, wire sampled mid high phase
   task automatic bitx(input logic b, output logic s);
      sdaDrv <= b;
      wt(2);
      scl <= 1'b1;
      wt(2);
      @(negedge ref_clk) s = sdaIn;
      @(posedge ref_clk) scl <= 1'b0;
      wt(1);
   endtask
   // Byte MSB first, then the acknowledge bit
   task automatic xbyte(input logic [7:0] w, input logic m, output logic [7:0] r,
                        output logic a);
      for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
      bitx(m, a);
   endtask
endmodule

// *** sim/cfg_checks_assertions.sv ***
// Port-level checks of the clock and receiver configuration block
module cfg_checks (
   input wire logic                         ref_clk,
   input wire logic                         rstn,
   input wire bridge_cfg_pkg::pll_cfg_t     pllCfg,
   input wire bridge_cfg_pkg::rx_cfg_t      rxCfg,
   input wire bridge_cfg_pkg::derived_cfg_t derivedCfg,
   input wire logic                         pllRunning,
   input wire logic                         softResetPulse,
   input wire logic                         pixelTick
);
   timeunit 1ns;
   timeprecision 1ps;
   import bridge_cfg_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Decoded values lag the stored codes by one cycle
   a_lane_decode: assert property (
      derivedCfg.activeLanes == 3'd4 - {1'b0, $past(rxCfg.input_lane_count)})
      else $error("active lane count wrong");
   a_divide_clamp: assert property (
      $past(pllCfg.pixel_clock_source_select) |-> derivedCfg.divideEffective ==
      (($past(pllCfg.hsDivideCode) > DIVIDE_CODE_MAX) ? DIVIDE_CODE_MAX :
       $past(pllCfg.hsDivideCode)))
      else $error("divide code wrong");
   a_divide_refzero: assert property (
      !$past(pllCfg.pixel_clock_source_select) |-> derivedCfg.divideEffective == 5'h00)
      else $error("divide not zero on reference");
   a_mult_select: assert property (
      derivedCfg.multiplyEffective == ($past(pllCfg.pixel_clock_source_select) ? 2'h0 :
      $past(pllCfg.ref_clock_multiply_code)))
      else $error("multiply code wrong");
   a_band_valid: assert property (
      derivedCfg.bandValid == ($past(rxCfg.input_clock_band_code) inside
      {[BAND_CODE_MIN:BAND_CODE_MAX]}))
      else $error("band valid wrong");
   // ==========================================================
   // PLL run state and output ticks
   a_pll_status: assert property (
      $changed(pllCfg.pllEnable) |=> pllRunning == $past(pllCfg.pllEnable))
      else $error("run status late");
   a_pixel_gated: assert property (
      pixelTick |-> pllRunning || $past(pllRunning))
      else $error("tick while stopped");
   a_soft_pulse: assert property (
      softResetPulse |=> !softResetPulse)
      else $error("soft reset pulse too long");
endmodule

// *** sim/dsi_rx_clock_pll_config_tb.sv ***
// Self-checking bench of the clock and receiver configuration block
module dsi_rx_clock_pll_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bridge_cfg_pkg::*;
   logic         ref_clk = 1'b0;
   logic         rstn    = 1'b0;
   logic         scl, sdaIn, sdaOut, sdaOeN, hsClkTick, refClkTick;
   pll_cfg_t     pllCfg;
   rx_cfg_t      rxCfg;
   derived_cfg_t derivedCfg;
   logic         pllRunning, softResetPulse, pixelTick;
   int           fails = 0;
   int           compares = 0;
   int           cyc = 0;
   int           pulses = 0;  // Soft reset strobes seen
   int           n;
   logic [7:0]   r8;
   logic         a;
   logic [7:0]   band [4] = '{8'h07, 8'h08, 8'h64, 8'h65};  // Edges of the valid span
   logic [3:0]   bandOk = 4'b0110;
   bridge_clock_config u_dut (.ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOeN(sdaOeN), .hsClkTick(hsClkTick), .refClkTick(refClkTick),
      .pllCfg(pllCfg), .rxCfg(rxCfg), .derivedCfg(derivedCfg), .pllRunning(pllRunning),
      .softResetPulse(softResetPulse), .pixelTick(pixelTick));
   cfg_host_model u_host (.ref_clk(ref_clk), .sdaOeN(sdaOeN), .scl(scl), .sdaIn(sdaIn),
      .hsClkTick(hsClkTick), .refClkTick(refClkTick));
   initial forever #20 ref_clk = ~ref_clk;
   // Ceiling well above the full run, cuts a hung bus short
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (softResetPulse) pulses++;
      if (cyc == 60000) begin
         fails++;
         end_sim();
      end
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Burst write of n bytes from the top of d, auto-increment
   task automatic wr(input logic [7:0] sub, input logic [23:0] d, input int n);
      u_host.start();
      u_host.xbyte({DEVICE_ADDR_DEF, 1'b0}, 1'b1, r8, a);
      check("address ack", 8'(a), 8'h00);
      u_host.xbyte(sub, 1'b1, r8, a);
      for (int i = 0; i < n; i++) u_host.xbyte(d[23-8*i -: 8], 1'b1, r8, a);
      u_host.stop();
   endtask
   // Read one byte via repeated start, then compare
   task automatic rc(input logic [7:0] sub, input logic [7:0] exp, input string name);
      logic [7:0] v;
      u_host.start();
      u_host.xbyte({DEVICE_ADDR_DEF, 1'b0}, 1'b1, r8, a);
      u_host.xbyte(sub, 1'b1, r8, a);
      u_host.start();
      u_host.xbyte({DEVICE_ADDR_DEF, 1'b1}, 1'b1, r8, a);
      u_host.xbyte(8'hFF, 1'b1, v, a);
      u_host.stop();
      check(name, v, exp);
   endtask
   // Cycles between two output ticks
   task automatic period(output int n);
      n = 0;
      @(negedge ref_clk iff pixelTick);
      do begin
         @(negedge ref_clk);
         n++;
      end while (!pixelTick && n < 200);
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rc(CLK_DIV_MULT_OFS, 8'h00, "divide multiply");
      rc(PLL_CONTROL_OFS, 8'h00, "pll control");
      rc(LANE_SETUP_OFS, 8'h18, "lane setup");
      rc(EQUALIZATION_OFS, 8'h00, "equalization");
      rc(CLOCK_BAND_OFS, 8'h00, "clock band");
      // Every lane, tolerance, equalization code; reserved bits set
      for (int i = 0; i < 4; i++) begin
         wr(LANE_SETUP_OFS, {3'h7, i[1:0], 2'h3, i[0], i[1:0], 2'h3, i[1:0], 2'h3, band[i]}, 3);
         check("active lanes", 8'(derivedCfg.activeLanes), 8'(4 - i));
         check("tolerance off", 8'(rxCfg.leader_error_tolerance_off), 8'(i[0]));
         check("band valid", 8'(derivedCfg.bandValid), 8'(bandOk[i]));
         rc(LANE_SETUP_OFS, {3'h0, i[1:0], 2'h0, i[0]}, "lane setup");
         rc(EQUALIZATION_OFS, {i[1:0], 2'h0, i[1:0], 2'h0}, "equalization");
         rc(CLOCK_BAND_OFS, band[i], "clock band");
      end
      // HS source, divide by 3; HS tick every 3 cycles
      wr(CLOCK_SOURCE_OFS, {8'h0B, 8'h10, 8'h00}, 2);
      wr(PLL_CONTROL_OFS, 24'h010000, 1);
      // no lock wait: lock is not modelled
      rc(CLOCK_SOURCE_OFS, 8'h8B, "source status");
      period(n);
      check("divide 3 period", 8'(n), 8'd9);
      // Disable first, then an out-of-range divide code
      wr(PLL_CONTROL_OFS, 24'hFE0000, 1);
      rc(PLL_CONTROL_OFS, 8'h00, "pll control");
      check("pll stopped", 8'(pllRunning), 8'h00);
      wr(CLK_DIV_MULT_OFS, 24'hFC0000, 1);
      rc(CLK_DIV_MULT_OFS, 8'hF8, "divide multiply");
      check("divide clamp", 8'(derivedCfg.divideEffective), 8'h18);
      wr(PLL_CONTROL_OFS, 24'h010000, 1);
      period(n);
      check("divide 25 period", 8'(n), 8'd75);
      // Reference source, multiply by 4, divide zeroed
      wr(PLL_CONTROL_OFS, 24'h000000, 1);
      wr(CLOCK_SOURCE_OFS, {8'h0A, 8'h03, 8'h00}, 2);
      check("ref divide", 8'(derivedCfg.divideEffective), 8'h00);
      check("ref multiply", 8'(derivedCfg.multiplyEffective), 8'h03);
      wr(PLL_CONTROL_OFS, 24'h010000, 1);
      period(n);
      check("ref period", 8'(n), 8'd2);
      // Soft reset keeps registers
      wr(SOFT_RESET_OFS, 24'h010000, 1);
      check("soft pulses", 8'(pulses), 8'h01);
      rc(SOFT_RESET_OFS, 8'h00, "soft reset");
      rc(CLK_DIV_MULT_OFS, 8'h03, "divide multiply");
      check("pll kept", 8'(pllRunning), 8'h01);
      rc(8'h20, 8'h00, "unmapped");
      // Foreign address gets no acknowledge
      u_host.start();
      u_host.xbyte({~DEVICE_ADDR_DEF, 1'b0}, 1'b1, r8, a);
      check("foreign ack", 8'(a), 8'h01);
      u_host.stop();
      end_sim();
   end
endmodule
bind bridge_clock_config cfg_checks u_chk (.ref_clk(ref_clk), .rstn(rstn), .pllCfg(pllCfg),
   .rxCfg(rxCfg), .derivedCfg(derivedCfg), .pllRunning(pllRunning),
   .softResetPulse(softResetPulse), .pixelTick(pixelTick));
